// ==== design/drs_deint_rs.sv ====
`timescale 1ns/1ps
module drs_buf #(
    parameter int W = 10,
    parameter int D = 2
) (
    input  wire logic         clock,
    input  wire logic         rst_b,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    logic [W-1:0]  mem [0:D-1];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    logic          wr;
    logic          rd;

    assign in_ready  = cnt_r != (AW+1)'(D);
    assign out_valid = cnt_r != '0;
    assign out_data  = mem[rp_r];
    assign wr        = in_valid && in_ready;
    assign rd        = out_valid && out_ready;

    always_ff @(posedge clock) begin
        if (wr) mem[wp_r] <= in_data;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (wr) wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
            if (rd) rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
            cnt_r <= cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
        end
    end
endmodule : drs_buf

module drs_deint_rs
    import drs_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        in_valid,
    output logic             in_ready,
    input  wire logic [7:0]  in_data,
    input  wire logic        in_sync,
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic [7:0]       out_data,
    output logic             out_sof,
    output logic             uncorrectable_flag_n,
    output logic             uncorrectable_pin,
    output logic [15:0]      corr_byte_cnt,
    output logic [15:0]      uncorrectable_pin_cw_cnt
);
    logic [8:0]       di_mem [0:(1<<DI_AW)-1];
    logic [7:0]       cw_mem [0:511];
    logic [7:0]       err_mem [0:255];
    logic [3:0]       br_r;
    logic [3:0]       cur_br;
    logic [DI_AW-1:0] wp_r;
    logic [DI_AW-1:0] di_dly;
    logic [11:0]      prime_cnt_r;
    logic             in_fire;
    logic             dv_r;
    logic             dsof_r;
    logic [7:0]       dd_r;
    logic [7:0]       col_cnt_r;
    logic [7:0]       idx;
    logic             col_sync_r;
    logic             col_full_r;
    logic             wb_r;
    logic             act;
    logic             last;
    logic             take;
    logic [7:0]       csyn [0:RS_R-1];
    logic [7:0]       syn [0:RS_R-1];
    logic [7:0]       lam [0:RS_R];
    logic [7:0]       bb [0:RS_R];
    logic [7:0]       omg [0:RS_R-1];
    logic [7:0]       lt [0:RS_R];
    logic [7:0]       ot [0:RS_R-1];
    logic [4:0]       len_r;
    logic [4:0]       r_r;
    drs_st_e          st_r;
    logic             eb_r;
    logic [7:0]       sc_r;
    logic [7:0]       oc_r;
    logic [7:0]       nroot_r;
    logic             bad_r;
    logic [7:0]       delta;
    logic [7:0]       dinv;
    logic [7:0]       lsum;
    logic [7:0]       odd;
    logic [7:0]       osum;
    logic             eng_unc;
    logic             push;
    logic             f_ready;
    logic [7:0]       raw;
    logic [7:0]       err;
    logic [7:0]       pdata;
    logic [9:0]       head;

    // Deinterleaver: one circular RAM, each branch reads at its own lag
    assign in_fire = in_valid && in_ready;
    assign cur_br  = in_sync ? 4'h0 : br_r;
    assign di_dly  = DI_AW'(int'(DI_BR_LAST - cur_br) * DI_M * DI_B);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            br_r <= 4'h0;
        end else if (in_fire) begin
            if (in_sync) br_r <= BR_AFTER_SYNC;
            else if (br_r == DI_BR_LAST) br_r <= 4'h0;
            else br_r <= br_r + 4'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (in_fire) begin
            di_mem[wp_r] <= {in_sync, in_data};
            if (di_dly == '0) {dsof_r, dd_r} <= {in_sync, in_data};
            else {dsof_r, dd_r} <= di_mem[wp_r - di_dly];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wp_r        <= '0;
            prime_cnt_r <= '0;
            dv_r        <= 1'b0;
        end else begin
            dv_r <= in_fire && (prime_cnt_r == DI_PRIME);
            if (in_fire) wp_r <= wp_r + 1'b1;
            if (in_fire && prime_cnt_r != DI_PRIME) prime_cnt_r <= prime_cnt_r + 12'h001;
        end
    end

    // Collector: codeword bank and syndromes, stalls upstream when both banks busy
    assign idx      = dsof_r ? 8'h00 : col_cnt_r;
    assign act      = dv_r && (col_sync_r || dsof_r);
    assign last     = act && idx == RS_LAST;
    assign take     = col_full_r && st_r == ST_IDLE;
    assign in_ready = !col_full_r && !last;

    always_ff @(posedge clock) begin
        if (act) begin
            cw_mem[{wb_r, idx}] <= dd_r;
            for (int i = 0; i < RS_R; i++) begin
                csyn[i] <= ((idx == 8'h00) ? 8'h00 : gf_mul(csyn[i], gf_apow(i))) ^ dd_r;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            col_cnt_r  <= 8'h00;
            col_sync_r <= 1'b0;
            col_full_r <= 1'b0;
            wb_r       <= 1'b0;
        end else begin
            if (act) col_cnt_r <= idx + 8'h01;
            if (dv_r && dsof_r) col_sync_r <= 1'b1;
            if (last) col_full_r <= 1'b1;
            else if (take) col_full_r <= 1'b0;
            if (take) wb_r <= !wb_r;
        end
    end

    // Shared sum: discrepancy during BM, evaluator coefficient afterwards
    always_comb begin
        delta = 8'h00;
        for (int j = 0; j <= RS_R; j++) begin
            if (j <= int'(r_r)) delta = delta ^ gf_mul(lam[j], syn[4'(int'(r_r) - j)]);
        end
        dinv = gf_inv(delta);
        lsum = 8'h00;
        odd  = 8'h00;
        osum = 8'h00;
        for (int j = 0; j <= RS_R; j++) begin
            lsum = lsum ^ lt[j];
            if (j % 2 == 1) odd = odd ^ lt[j];
        end
        for (int k = 0; k < RS_R; k++) begin
            osum = osum ^ ot[k];
        end
    end

    // Decode engine
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            st_r    <= ST_IDLE;
            r_r     <= 5'h00;
            len_r   <= 5'h00;
            sc_r    <= 8'h00;
            oc_r    <= 8'h00;
            eb_r    <= 1'b0;
            nroot_r <= 8'h00;
            bad_r   <= 1'b0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    if (take) begin
                        st_r    <= ST_BM;
                        eb_r    <= wb_r;
                        r_r     <= 5'h00;
                        len_r   <= 5'h00;
                        nroot_r <= 8'h00;
                        bad_r   <= 1'b0;
                    end
                end
                ST_BM: begin
                    if (delta != 8'h00 && 6'({len_r, 1'b0}) <= 6'(r_r)) len_r <= 5'(r_r + 5'h01 - len_r);
                    r_r <= (r_r == BM_LAST) ? 5'h00 : r_r + 5'h01;
                    if (r_r == BM_LAST) st_r <= ST_OMG;
                end
                ST_OMG: begin
                    r_r <= r_r + 5'h01;
                    if (r_r == BM_LAST) begin
                        st_r <= ST_CHN;
                        sc_r <= 8'h00;
                    end
                end
                ST_CHN: begin
                    sc_r <= sc_r + 8'h01;
                    if (sc_r >= CHN_FIRST && lsum == 8'h00) begin
                        nroot_r <= nroot_r + 8'h01;
                        if (odd == 8'h00) bad_r <= 1'b1;
                    end
                    if (sc_r == CHN_LAST) begin
                        st_r <= ST_OUT;
                        oc_r <= 8'h00;
                    end
                end
                ST_OUT: begin
                    if (push) begin
                        // Wrap at codeword end so the next pass starts from byte zero
                        oc_r <= (oc_r == RS_LAST) ? 8'h00 : oc_r + 8'h01;
                        if (oc_r == RS_LAST) st_r <= ST_IDLE;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (take) begin
            for (int i = 0; i < RS_R; i++) syn[i] <= csyn[i];
            for (int j = 0; j <= RS_R; j++) lam[j] <= (j == 0) ? 8'h01 : 8'h00;
            for (int j = 0; j <= RS_R; j++) bb[j] <= (j == 0) ? 8'h01 : 8'h00;
        end else if (st_r == ST_BM) begin
            for (int j = 0; j <= RS_R; j++) begin
                lam[j] <= lam[j] ^ gf_mul(delta, (j == 0) ? 8'h00 : bb[j-1]);
                if (delta != 8'h00 && 6'({len_r, 1'b0}) <= 6'(r_r)) bb[j] <= gf_mul(lam[j], dinv);
                else bb[j] <= (j == 0) ? 8'h00 : bb[j-1];
            end
        end
        if (st_r == ST_OMG) omg[r_r[3:0]] <= delta;
    end

    // Chien terms: step s evaluates at x = alpha^s, i.e. byte s - CHN_FIRST
    always_ff @(posedge clock) begin
        if (st_r == ST_CHN) begin
            for (int j = 0; j <= RS_R; j++) begin
                lt[j] <= gf_mul((sc_r == 8'h00) ? lam[j] : lt[j], gf_apow(j));
            end
            for (int k = 0; k < RS_R; k++) begin
                ot[k] <= gf_mul((sc_r == 8'h00) ? omg[k] : ot[k], gf_apow(k));
            end
            if (sc_r >= CHN_FIRST) begin
                err_mem[sc_r - CHN_FIRST] <= (lsum == 8'h00) ? gf_mul(osum, gf_inv(odd)) : 8'h00;
            end
        end
    end

    // Output pass through the two-entry buffer
    assign eng_unc = (nroot_r != {3'b000, len_r}) || (len_r > RS_T5) || bad_r;
    assign push    = st_r == ST_OUT && f_ready;
    assign raw     = cw_mem[{eb_r, oc_r}];
    assign err     = err_mem[oc_r];
    assign pdata   = eng_unc ? raw : raw ^ err;

    drs_buf #(.W(10), .D(2)) u_buf (
        .clock     (clock),
        .rst_b     (rst_b),
        .in_valid  (st_r == ST_OUT),
        .in_ready  (f_ready),
        .in_data   ({oc_r == 8'h00, eng_unc, pdata}),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (head)
    );

    assign out_data             = head[7:0];
    assign out_sof              = head[9];
    assign uncorrectable_pin    = out_valid && head[8];
    assign uncorrectable_flag_n = !uncorrectable_pin;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            corr_byte_cnt <= 16'h0000;
            uncorrectable_pin_cw_cnt <= 16'h0000;
        end else begin
            if (push && !eng_unc && err != 8'h00) corr_byte_cnt <= corr_byte_cnt + 16'h0001;
            if (push && eng_unc && oc_r == RS_LAST) uncorrectable_pin_cw_cnt <= uncorrectable_pin_cw_cnt + 16'h0001;
        end
    end

    property p_sync_align;
        @(posedge clock) disable iff (!rst_b) in_fire && in_sync |=> br_r == BR_AFTER_SYNC;
    endproperty
    a_sync_align: assert property (p_sync_align) else $error("branch not realigned");

    property p_br_wrap;
        @(posedge clock) disable iff (!rst_b) in_fire && !in_sync && br_r == DI_BR_LAST |=> br_r == 4'h0;
    endproperty
    a_br_wrap: assert property (p_br_wrap) else $error("branch did not wrap");

    property p_prime;
        @(posedge clock) disable iff (!rst_b) dv_r |-> $past(prime_cnt_r) == DI_PRIME;
    endproperty
    a_prime: assert property (p_prime) else $error("output before delay filled");

    property p_full;
        @(posedge clock) disable iff (!rst_b) last |-> !in_ready ##1 (col_full_r && !in_ready);
    endproperty
    a_full: assert property (p_full) else $error("codeword end not held");

    property p_bm_time;
        @(posedge clock) disable iff (!rst_b) $rose(st_r == ST_BM) |-> ##16 st_r == ST_OMG;
    endproperty
    a_bm_time: assert property (p_bm_time) else $error("BM length wrong");

    property p_chien_time;
        @(posedge clock) disable iff (!rst_b) $rose(st_r == ST_CHN) |-> ##256 st_r == ST_OUT;
    endproperty
    a_chien_time: assert property (p_chien_time) else $error("search length wrong");

    property p_limit;
        @(posedge clock) disable iff (!rst_b) push && len_r > RS_T5 |-> eng_unc && pdata == raw;
    endproperty
    a_limit: assert property (p_limit) else $error("over-limit codeword not flagged");

    property p_pins;
        @(posedge clock) disable iff (!rst_b) out_valid && head[8] |-> !uncorrectable_flag_n && uncorrectable_pin;
    endproperty
    a_pins: assert property (p_pins) else $error("flag pins disagree");

    property p_order;
        @(posedge clock) disable iff (!rst_b) push && oc_r == RS_LAST |=> st_r == ST_IDLE && oc_r == 8'h00 || take;
    endproperty
    a_order: assert property (p_order) else $error("codeword end missed");

    property p_clean;
        @(posedge clock) disable iff (!rst_b) push && (eng_unc || err == 8'h00) |-> pdata == raw;
    endproperty
    a_clean: assert property (p_clean) else $error("byte altered wrongly");
endmodule : drs_deint_rs

// ==== design/drs_pkg.sv ====
// Operation
// - Deinterleave the byte stream convolutionally over 204-byte blocks.
// - Twelve branches; the branch delay steps are fixed.
// - Delay unit M is the block length over the depth, rounded up.
// - Inverse ordering turns short channel bursts into single byte errors.
// - First valid byte leaves after the full deinterleaver delay.
// - Recover block boundaries as strobes; delays held in RAM delay lines.
// - Reed-Solomon codewords are exactly 204 bytes.
// - Shortened (204,188) code: 188 message bytes plus check bytes.
// - Correct at most 8 byte errors per codeword.
// - Systematic codeword: message bytes first, then check bytes.
// - Generator roots are alpha^0 through alpha^(R-1).
// - Field built on x^8 + x^4 + x^3 + x^2 + 1.
// - Byte bit d7 is the alpha^7 coefficient, d0 the constant.
// - Within the limit, every wrong byte is corrected before output.
// - Beyond the limit, drive the active-low uncorrectable flag low.
// - Any number of wrong bits in a byte is one byte error.
// - Uncorrectable pin plus counts of uncorrected and corrected data.
// - Hold bytes until corrections are ready, then apply them.
// - Chien search finds roots and evaluates the error values.
package drs_pkg;
    localparam int         DI_N          = 204;
    localparam int         DI_B          = 12;
    localparam int         DI_M          = (DI_N + DI_B - 1) / DI_B;
    localparam int         DI_AW         = 12;
    localparam logic [3:0] DI_BR_LAST    = 4'(DI_B - 1);
    localparam logic [3:0] BR_AFTER_SYNC = 4'h1;
    localparam logic [11:0] DI_PRIME     = 12'((DI_B - 1) * DI_B * DI_M);
    // First output in clocks at one byte every eight clocks
    localparam int         DI_FIRST_CYC  = ((DI_B - 1) * DI_B * DI_M + 1) * 8 + 1;
    localparam int         RS_N          = DI_N;
    localparam int         RS_K          = 188;
    localparam int         RS_R          = RS_N - RS_K;
    localparam int         RS_T          = RS_R / 2;
    localparam logic [7:0] RS_LAST       = 8'(RS_N - 1);
    localparam logic [7:0] CHN_FIRST     = 8'(256 - RS_N);
    localparam logic [7:0] CHN_LAST      = 8'hFF;
    localparam logic [4:0] BM_LAST       = 5'(RS_R - 1);
    localparam logic [4:0] RS_T5         = 5'(RS_T);
    localparam logic [7:0] GF_POLY       = 8'h1D;
    localparam logic [7:0] GF_ALPHA      = 8'h02;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_BM   = 5'h02,
        ST_OMG  = 5'h04,
        ST_CHN  = 5'h08,
        ST_OUT  = 5'h10
    } drs_st_e;

    function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        p = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            p = {p[6:0], 1'b0} ^ (p[7] ? GF_POLY : 8'h00) ^ (b[i] ? a : 8'h00);
        end
        return p;
    endfunction : gf_mul

    // a^254; zero maps to zero
    function automatic logic [7:0] gf_inv(input logic [7:0] a);
        logic [7:0] x;
        logic [7:0] r;
        x = a;
        r = 8'h01;
        for (int i = 1; i < 8; i++) begin
            x = gf_mul(x, x);
            r = gf_mul(r, x);
        end
        return r;
    endfunction : gf_inv

    function automatic logic [7:0] gf_apow(input int n);
        logic [7:0] r;
        r = 8'h01;
        for (int i = 0; i < 17; i++) begin
            if (i < n) r = gf_mul(r, GF_ALPHA);
        end
        return r;
    endfunction : gf_apow
endpackage : drs_pkg

// ==== bench/drs_far_end.sv ====
`timescale 1ns/1ps
module drs_far_end (
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic stall,
    output logic      out_ready
);
    // Random back-pressure; a long stall on request fills the buffer
    initial out_ready = 1'b0;
    always @(negedge clock) begin
        if (!rst_b || stall) begin
            out_ready <= 1'b0;
        end else begin
            out_ready <= ($urandom_range(0, 3) != 0);
        end
    end
endmodule : drs_far_end

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb;
    import drs_pkg::*;
    localparam int NT = 16;
    // Eleven extra codewords push the last compared one through the delay lines
    localparam int NC = NT + 11;
    localparam int NJ = 5;
    logic        clock;
    logic        rst_b;
    logic        in_valid;
    logic        in_ready;
    logic [7:0]  in_data;
    logic        in_sync;
    logic        out_valid;
    logic        out_ready;
    logic [7:0]  out_data;
    logic        out_sof;
    logic        uncorrectable_flag_n;
    logic        uncorrectable_pin;
    logic [15:0] corr_byte_cnt;
    logic [15:0] uncorrectable_pin_cw_cnt;
    logic        stall;
    logic        saw_block;
    logic        first_seen;
    int          errors;
    int          checks_done;
    int          taken;
    logic [7:0]  src [NC*204];
    logic [7:0]  rx [NC*204];
    logic [7:0]  chan [NC*204];
    logic [7:0]  g [17];
    logic [9:0]  exp_q [$];
    logic [9:0]  e;

    drs_deint_rs u_drs_deint_rs (.clock(clock), .rst_b(rst_b), .in_valid(in_valid), .in_ready(in_ready),
        .in_data(in_data), .in_sync(in_sync), .out_valid(out_valid), .out_ready(out_ready),
        .out_data(out_data), .out_sof(out_sof), .uncorrectable_flag_n(uncorrectable_flag_n),
        .uncorrectable_pin(uncorrectable_pin), .corr_byte_cnt(corr_byte_cnt), .uncorrectable_pin_cw_cnt(uncorrectable_pin_cw_cnt));
    drs_far_end u_drs_far_end (.clock(clock), .rst_b(rst_b), .stall(stall), .out_ready(out_ready));

    always #4 clock = ~clock;

    // Shift-and-add multiply, kept apart from the design's own arithmetic
    function automatic logic [7:0] tb_gmul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        p = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) p = p ^ a;
            a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1D : 8'h00);
        end
        return p;
    endfunction : tb_gmul

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic final_report();
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    task automatic build();
        logic [7:0] p [16];
        logic [7:0] fb;
        logic [7:0] ai;
        g = '{default: 8'h00};
        g[0] = 8'h01;
        ai = 8'h01;
        for (int i = 0; i < 16; i++) begin
            for (int j = 16; j > 0; j--) g[j] = g[j-1] ^ tb_gmul(g[j], ai);
            g[0] = tb_gmul(g[0], ai);
            ai = tb_gmul(ai, 8'h02);
        end
        for (int c = 0; c < NC; c++) begin
            p = '{default: 8'h00};
            for (int i = 0; i < 188; i++) begin
                src[c*204+i] = 8'($urandom);
                fb = src[c*204+i] ^ p[15];
                for (int j = 15; j > 0; j--) p[j] = p[j-1] ^ tb_gmul(fb, g[j]);
                p[0] = tb_gmul(fb, g[0]);
            end
            for (int j = 0; j < 16; j++) src[c*204+188+j] = p[15-j];
        end
        rx = src;
        // All-ones mask on the first error: many wrong bits still make one byte error
        for (int i = 0; i < 8; i++) rx[204+23*i] ^= (i == 0) ? 8'hFF : 8'(i*37+1);
        for (int i = 0; i < 9; i++) rx[408+22*i] ^= (i == 0) ? 8'hFF : 8'(i*37+1);
        for (int i = 0; i < 8; i++) rx[612+188+2*i] ^= 8'(i*37+1);
        for (int t = 0; t < NC*204; t++) begin
            chan[t] = (t >= (t % 12) * 204) ? rx[t - (t % 12) * 204] : 8'($urandom);
        end
        // Channel burst of eleven bytes lands as one error in each of codewords 5..15
        for (int j = 0; j < 11; j++) chan[204*15+j] ^= 8'h5A;
        for (int c = 0; c < NT; c++) begin
            for (int i = 0; i < 204; i++) exp_q.push_back({i == 0, c == 2, (c == 2) ? rx[c*204+i] : src[c*204+i]});
        end
    endtask : build

    task automatic send(input logic [7:0] d, input logic s, input int gap);
        int n;
        n = 0;
        in_valid = 1'b1;
        in_data = d;
        in_sync = s;
        do begin
            @(posedge clock);
            n++;
        end while (in_ready !== 1'b1 && n < 20000);
        if (n >= 20000) check(32'h0, 32'h1, "input never accepted");
        @(negedge clock);
        if (gap > 0) in_valid = 1'b0;
        repeat (gap) @(negedge clock);
    endtask : send

    always @(posedge clock) begin
        if (rst_b && in_valid && in_ready === 1'b1) taken++;
        if (stall && in_valid && in_ready === 1'b0) saw_block = 1'b1;
        if (rst_b && out_valid === 1'b1 && out_ready === 1'b1) begin
            if (!first_seen) begin
                first_seen = 1'b1;
                check(32'(taken >= NJ + 2448 && taken <= NJ + 2448 + 45), 32'h1, "first output position");
            end
            if (exp_q.size() == 0) begin
                check(32'h0, 32'h1, "unexpected output");
            end else begin
                e = exp_q.pop_front();
                check(32'(out_data), 32'(e[7:0]), "data");
                check(32'(out_sof), 32'(e[9]), "sof");
                check(32'(uncorrectable_flag_n), 32'(!e[8]), "flag_n");
                check(32'(uncorrectable_pin), 32'(e[8]), "pin");
            end
        end
    end

    initial begin
        repeat (90000) @(posedge clock);
        errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        final_report();
    end

    initial begin
        int n;
        clock = 1'b0;
        rst_b = 1'b0;
        in_valid = 1'b0;
        in_data = 8'h00;
        in_sync = 1'b0;
        stall = 1'b0;
        saw_block = 1'b0;
        first_seen = 1'b0;
        errors = 0;
        checks_done = 0;
        taken = 0;
        void'($urandom(18505));
        build();
        repeat (3) @(negedge clock);
        check(32'({out_valid, uncorrectable_flag_n, uncorrectable_pin}), 32'h2, "reset outputs");
        check({corr_byte_cnt, uncorrectable_pin_cw_cnt}, 32'h0, "reset counts");
        rst_b = 1'b1;
        // Junk without a marker; the first marker must realign the branch
        for (int i = 0; i < NJ; i++) send(8'($urandom), 1'b0, 0);
        $display("test realign done");
        for (int t = 0; t < NC*204; t++) begin
            if (t == 3100) begin
                fork
                    begin
                        stall = 1'b1;
                        repeat (3000) @(negedge clock);
                        stall = 1'b0;
                    end
                join_none
            end
            send(chan[t], t % 204 == 0, (t < 2520) ? 7 : $urandom_range(0, 2));
        end
        in_valid = 1'b0;
        in_sync = 1'b0;
        $display("test stream done");
        n = 0;
        while (exp_q.size() != 0 && n < 20000) begin
            @(negedge clock);
            n++;
        end
        repeat (20) @(negedge clock);
        check(32'(exp_q.size()), 32'h0, "outputs missing");
        check(32'(saw_block), 32'h1, "input never refused under stall");
        check(32'(corr_byte_cnt), 32'h1B, "corrected byte count");
        check(32'(uncorrectable_pin_cw_cnt), 32'h1, "uncorrectable count");
        $display("test counters done");
        final_report();
    end
endmodule : tb
